// ---- lin_pkg.sv ----
// Constants, register map and state type of the LIN header-assist block.
// Notes on behaviour
// RQ1 - Master: timer run write 1 holds transmit pin low for the timer interval.
// RQ2 - Master: timer underflow releases transmit pin and sets break-done flag.
// RQ3 - Break flag with break interrupt enable raises the shared timer interrupt.
// RQ4 - After the master break, the sync byte 55h goes to the serial transmitter.
// RQ5 - After sync, identifier and response go through the serial port.
// RQ6 - Slave: software writes 1 to the arm bit to start break detection.
// RQ7 - Slave: low input for a timer period is a break; flag, interrupt, measure.
// RQ8 - Sync measurement times start bit plus data bits 0 to 6.
// RQ9 - Sync waveform reaches serial receive input per the unmask select bit.
// RQ10 - Sync measured sets its flag and interrupts when sync enable is 1.
// RQ11 - Software derives bit rate from count and reloads serial port and timer.
// RQ12 - Collision checking only while serial transmit enable is 1.
// RQ13 - Collision flag when sampled receive differs from driven transmit at latch.
// RQ14 - During communication a low longer than the break period flags break; code does this in slave mode only, once the timer is restarted.
// RQ15 - Four event sources merge onto one timer interrupt request.
// RQ16 - Software ends LIN after checksum with collision checks, else after header.
// RQ17 - Header and response timeouts use another timer; none here.
// RQ18 - Mode bit 0 is slave with break detector, 1 is master driving the break.
// RQ19 - Unmask select 0 reopens receive after break, 1 after sync measurement.
// RQ20 - Arm bit write 1 starts timer input and masks receive; reads as 0.
// RQ21 - Software clears operation start bit before changing master or slave.
// RQ22 - Each event flag stays set until software clears it.
package lin_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFF_LIN_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] OFF_LIN_STAT = 3'h1;
   localparam logic [ADDR_W-1:0] OFF_TMR_CTRL = 3'h2;
   localparam logic [ADDR_W-1:0] OFF_TMR_PRE = 3'h3;
   localparam logic [ADDR_W-1:0] OFF_TMR_CNT = 3'h4;
   localparam logic [ADDR_W-1:0] OFF_SER_CTRL1 = 3'h5;
   // Fields of lin_control_reg.
   localparam int CTL_SYNC_IE = 0;
   localparam int CTL_BRK_IE = 1;
   localparam int CTL_COL_IE = 2;
   localparam int CTL_MASKED = 3;
   localparam int CTL_ARM = 4;
   localparam int CTL_UNMASK_SEL = 5;
   localparam int CTL_MASTER = 6;
   localparam int CTL_LINE = 7;
   // Fields of lin_status_reg.
   localparam int STA_BRK_SEEN = 0;
   localparam int STA_BRK_DONE = 1;
   localparam int STA_SYNC = 2;
   localparam int STA_COL = 3;
   // Fields of timer_control_reg and serial_control1_reg.
   localparam int TCT_RUN = 0;
   localparam int TCT_BUSY = 1;
   localparam int SER_TX_EN_BIT = 0;
   // Timer values after reset, and the sync byte.
   localparam logic [DATA_W-1:0] TMR_PRE_RST = 8'hFF;
   localparam logic [DATA_W-1:0] TMR_CNT_RST = 8'hFF;
   localparam logic [DATA_W-1:0] SYNC_BYTE = 8'h55;
   // Falling edges of the sync byte from start bit to the edge after bit 6.
   localparam logic [2:0] SYNC_FALLS = 3'h5;
   typedef enum logic [2:0] {
      ST_IDLE, ST_BRK_GEN, ST_SYNC_TX, ST_BRK_WAIT, ST_BRK_HIGH, ST_SYNC_WAIT,
      ST_SYNC_MEAS, ST_COMM
   } state_type;
endpackage : lin_pkg

// ---- timer_if.sv ----
// Control and status signals between the header logic and its interval timer.
`timescale 1ns/1ps
interface timer_if;
   logic run;
   logic reload;
   logic measure;
   logic [7:0] pre_val;
   logic [7:0] cnt_val;
   logic underflow;
   logic [15:0] count;
   modport ctl (output run, output reload, output measure, output pre_val, output cnt_val,
      input underflow, input count);
   modport tmr (input run, input reload, input measure, input pre_val, input cnt_val,
      output underflow, output count);
endinterface : timer_if

// ---- lin_timer.sv ----
// Interval timer with prescaler and counter, down-counting or measuring up.
`timescale 1ns/1ps
module lin_timer (
   input wire logic clk,
   input wire logic rst_b,
   timer_if.tmr tif
);
   import lin_pkg::*;
   logic [7:0] pre_ff;
   logic [7:0] cnt_ff;
   logic uf_ff;

   // Reload, count up from zero when measuring, otherwise count down and reload from the reload values.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pre_ff <= TMR_PRE_RST;
         cnt_ff <= TMR_CNT_RST;
      end else if (tif.reload) begin
         if (tif.measure) begin
            {cnt_ff, pre_ff} <= 16'h0000;
         end else begin
            pre_ff <= tif.pre_val;
            cnt_ff <= tif.cnt_val;
         end
      end else if (tif.run) begin
         if (tif.measure) begin
            if ({cnt_ff, pre_ff} != 16'hFFFF) begin
               {cnt_ff, pre_ff} <= {cnt_ff, pre_ff} + 16'h0001;
            end
         end else if (pre_ff != 8'h00) begin
            pre_ff <= pre_ff - 8'h01;
         end else begin
            pre_ff <= tif.pre_val;
            if (cnt_ff == 8'h00) begin
               cnt_ff <= tif.cnt_val;
            end else begin
               cnt_ff <= cnt_ff - 8'h01;
            end
         end
      end
   end

   // Underflow pulse one cycle after the terminal count is passed.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         uf_ff <= 1'b0;
      end else begin
         uf_ff <= !tif.reload && tif.run && !tif.measure && (pre_ff == 8'h00) &&
            (cnt_ff == 8'h00);
      end
   end

   assign tif.underflow = uf_ff;
   assign tif.count = {cnt_ff, pre_ff};
endmodule : lin_timer

// ---- lin_header_assist.sv ----
// LIN header assist: break generation and detection, sync measurement, collisions.
`timescale 1ns/1ps
module lin_header_assist (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [lin_pkg::ADDR_W-1:0] ADDR,
   input wire logic [lin_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [lin_pkg::DATA_W-1:0] RDATA,
   input wire logic LIN_RX_PIN,
   output logic LIN_TX_PIN,
   input wire logic SER_TXD,
   output logic SER_RXD,
   output logic SER_TX_REQ,
   output logic [lin_pkg::DATA_W-1:0] SER_TX_DATA,
   input wire logic SER_TX_DONE,
   input wire logic SER_LATCH,
   output logic SER_TX_EN,
   output logic TIMER_IRQ
);
   import lin_pkg::*;

   // Register address match.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   timer_if tif ();

   state_type state_ff;
   state_type nxt_state;
   logic sync_ie_ff;
   logic brk_ie_ff;
   logic col_ie_ff;
   logic masked_ff;
   logic unmask_sel_ff;
   logic master_ff;
   logic line_ff;
   logic brk_seen_ff;
   logic brk_done_ff;
   logic sync_ff;
   logic col_ff;
   logic run_ff;
   logic [7:0] pre_ff;
   logic [7:0] cnt_ff;
   logic tx_en_ff;
   logic [2:0] falls_ff;
   logic rx_s1_ff;
   logic rx_s2_ff;
   logic rx_d_ff;
   logic tx_ff;
   logic ser_rxd_ff;
   logic req_ff;
   logic [7:0] data_ff;
   logic irq_ff;
   logic [7:0] rdata_ff;

   logic wr_ctl;
   logic wr_sta;
   logic wr_tct;
   logic wr_pre;
   logic wr_cnt;
   logic wr_ser;
   logic arm_wr;
   logic run_wr;
   logic rx_fall;
   logic watch;
   logic ev_brk_seen;
   logic ev_brk_done;
   logic ev_sync;
   logic ev_col;
   logic unmask_ev;
   logic nxt_tx;

   // Write decode for each register.
   assign wr_ctl = WR && hit(ADDR, OFF_LIN_CTRL);
   assign wr_sta = WR && hit(ADDR, OFF_LIN_STAT);
   assign wr_tct = WR && hit(ADDR, OFF_TMR_CTRL);
   assign wr_pre = WR && hit(ADDR, OFF_TMR_PRE);
   assign wr_cnt = WR && hit(ADDR, OFF_TMR_CNT);
   assign wr_ser = WR && hit(ADDR, OFF_SER_CTRL1);
   // RQ6 arm write strobe.
   assign arm_wr = wr_ctl && WDATA[CTL_ARM] && line_ff && !master_ff;
   assign run_wr = wr_tct && WDATA[TCT_RUN];

   // Receive pin passes two flip-flops; a third stage gives the edge detector.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_d_ff <= 1'b1;
      end else begin
         rx_s1_ff <= LIN_RX_PIN;
         rx_s2_ff <= rx_s1_ff;
         rx_d_ff <= rx_s2_ff;
      end
   end

   assign rx_fall = rx_d_ff && !rx_s2_ff;
   // RQ14 long-low watch armed once software restarts the timer in slave mode.
   assign watch = (state_ff == ST_COMM) && run_ff && !master_ff;

   // Event strobes.
   // RQ7 break detected when the timer runs out while the line stays low.
   assign ev_brk_seen = tif.underflow && !rx_s2_ff &&
      ((state_ff == ST_BRK_WAIT) || watch);
   // RQ2 break generation ends at the timer underflow.
   assign ev_brk_done = tif.underflow && (state_ff == ST_BRK_GEN);
   // RQ8 measurement ends on the fifth falling edge, after bit 6.
   assign ev_sync = (state_ff == ST_SYNC_MEAS) && rx_fall &&
      (falls_ff == SYNC_FALLS - 3'h1);
   // RQ12 checking only with serial transmit enabled.
   // RQ13 compare sampled receive with driven transmit at the latch point.
   assign ev_col = SER_LATCH && tx_en_ff && line_ff && (rx_s2_ff != tx_ff);
   // RQ19 unmask point chosen by the select bit.
   assign unmask_ev = unmask_sel_ff ? ev_sync : (ev_brk_seen && (state_ff == ST_BRK_WAIT));

   // Next state of the header sequencer.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            // RQ18 mode bit picks generator or detector.
            if (line_ff && master_ff && run_wr) begin
               nxt_state = ST_BRK_GEN;
            end else if (arm_wr) begin
               nxt_state = ST_BRK_WAIT;
            end
         end
         ST_BRK_GEN: begin
            if (ev_brk_done) begin
               nxt_state = ST_SYNC_TX;
            end
         end
         ST_SYNC_TX: begin
            // RQ5 serial port takes over after the sync byte.
            if (SER_TX_DONE) begin
               nxt_state = ST_COMM;
            end
         end
         ST_BRK_WAIT: begin
            if (ev_brk_seen) begin
               nxt_state = ST_BRK_HIGH;
            end
         end
         ST_BRK_HIGH: begin
            if (rx_s2_ff) begin
               nxt_state = ST_SYNC_WAIT;
            end
         end
         ST_SYNC_WAIT: begin
            if (rx_fall) begin
               nxt_state = ST_SYNC_MEAS;
            end
         end
         ST_SYNC_MEAS: begin
            if (ev_sync) begin
               nxt_state = ST_COMM;
            end
         end
         ST_COMM: begin
            if (line_ff && master_ff && run_wr) begin
               nxt_state = ST_BRK_GEN;
            end else if (arm_wr) begin
               nxt_state = ST_BRK_WAIT;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (!line_ff) begin
         nxt_state = ST_IDLE;
      end
   end

   // State register.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Falling edges counted during sync measurement.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         falls_ff <= 3'h0;
      end else if (state_ff == ST_SYNC_WAIT) begin
         falls_ff <= 3'h1;
      end else if ((state_ff == ST_SYNC_MEAS) && rx_fall) begin
         falls_ff <= falls_ff + 3'h1;
      end
   end

   // Timer steering.
   // RQ1 timer runs for the whole break in master mode.
   assign tif.run = (state_ff == ST_BRK_GEN) || (state_ff == ST_SYNC_MEAS) ||
      (((state_ff == ST_BRK_WAIT) || watch) && !rx_s2_ff);
   // RQ20 timer input restarts on each high level while armed.
   assign tif.reload = (nxt_state == ST_BRK_GEN && state_ff != ST_BRK_GEN) ||
      (nxt_state == ST_BRK_WAIT && state_ff != ST_BRK_WAIT) ||
      (((state_ff == ST_BRK_WAIT) || watch) && rx_s2_ff) ||
      ((state_ff == ST_SYNC_WAIT) && rx_fall) ||
      ((state_ff == ST_IDLE) && (wr_pre || wr_cnt));
   assign tif.measure = (state_ff == ST_SYNC_WAIT) || (state_ff == ST_SYNC_MEAS);
   assign tif.pre_val = wr_pre ? WDATA : pre_ff;
   assign tif.cnt_val = wr_cnt ? WDATA : cnt_ff;

   lin_timer u_timer (
      .clk(CLK),
      .rst_b(RST_B),
      .tif(tif)
   );

   // Control register; mode bit only follows while operation is stopped.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         sync_ie_ff <= 1'b0;
         brk_ie_ff <= 1'b0;
         col_ie_ff <= 1'b0;
         unmask_sel_ff <= 1'b0;
         master_ff <= 1'b0;
         line_ff <= 1'b0;
      end else if (wr_ctl) begin
         sync_ie_ff <= WDATA[CTL_SYNC_IE];
         brk_ie_ff <= WDATA[CTL_BRK_IE];
         col_ie_ff <= WDATA[CTL_COL_IE];
         unmask_sel_ff <= WDATA[CTL_UNMASK_SEL];
         line_ff <= WDATA[CTL_LINE];
         // RQ21 mode change taken only while stopped.
         if (!line_ff) begin
            master_ff <= WDATA[CTL_MASTER];
         end
      end
   end

   // Receive mask: set by arming, cleared at the unmask point or by writing 0.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         masked_ff <= 1'b0;
      end else if (arm_wr) begin
         // RQ20 arming blocks the serial receive input.
         masked_ff <= 1'b1;
      end else if (unmask_ev || !line_ff || master_ff) begin
         masked_ff <= 1'b0;
      end else if (wr_ctl && !WDATA[CTL_MASKED]) begin
         masked_ff <= 1'b0;
      end
   end

   // Sticky event flags; write 1 clears, a new event wins over the clear.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         brk_seen_ff <= 1'b0;
         brk_done_ff <= 1'b0;
         sync_ff <= 1'b0;
         col_ff <= 1'b0;
      end else begin
         // RQ22 flags hold until cleared.
         brk_seen_ff <= ev_brk_seen || (brk_seen_ff && !(wr_sta && WDATA[STA_BRK_SEEN]));
         brk_done_ff <= ev_brk_done || (brk_done_ff && !(wr_sta && WDATA[STA_BRK_DONE]));
         // RQ10 sync measured flag.
         sync_ff <= ev_sync || (sync_ff && !(wr_sta && WDATA[STA_SYNC]));
         col_ff <= ev_col || (col_ff && !(wr_sta && WDATA[STA_COL]));
      end
   end

   // Timer run bit, reload values and serial transmit enable.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         run_ff <= 1'b0;
         pre_ff <= TMR_PRE_RST;
         cnt_ff <= TMR_CNT_RST;
         tx_en_ff <= 1'b0;
      end else begin
         if (ev_brk_done || !line_ff) begin
            run_ff <= 1'b0;
         end else if (wr_tct) begin
            run_ff <= WDATA[TCT_RUN];
         end
         if (wr_pre) begin
            pre_ff <= WDATA;
         end
         if (wr_cnt) begin
            cnt_ff <= WDATA;
         end
         if (wr_ser) begin
            tx_en_ff <= WDATA[SER_TX_EN_BIT];
         end
      end
   end

   // Transmit pin: break low ANDed with serial transmit data.
   always_comb begin
      nxt_tx = SER_TXD;
      // RQ1 hold the pin low during the break.
      if (state_ff == ST_BRK_GEN) begin
         nxt_tx = 1'b0;
      end
   end

   // Pin and serial-port outputs.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_ff <= 1'b1;
         ser_rxd_ff <= 1'b1;
      end else begin
         tx_ff <= nxt_tx;
         // RQ9 masked receive reads idle high at the serial port.
         ser_rxd_ff <= masked_ff ? 1'b1 : rx_s2_ff;
      end
   end

   // Sync byte request to the serial transmitter.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         req_ff <= 1'b0;
         data_ff <= 8'h00;
      end else begin
         // RQ4 send 55h after the break.
         req_ff <= ev_brk_done;
         if (ev_brk_done) begin
            data_ff <= SYNC_BYTE;
         end
      end
   end

   // Shared timer interrupt from enabled flags.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         irq_ff <= 1'b0;
      end else begin
         // RQ3 break flags gated by break enable.
         // RQ15 four sources onto one line.
         irq_ff <= ((brk_seen_ff || brk_done_ff) && brk_ie_ff) || (sync_ff && sync_ie_ff) ||
            (col_ff && col_ie_ff);
      end
   end

   // Read data one cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_ff <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            OFF_LIN_CTRL: begin
               // RQ20 arm bit reads back as 0.
               rdata_ff <= {line_ff, master_ff, unmask_sel_ff, 1'b0, masked_ff, col_ie_ff,
                  brk_ie_ff, sync_ie_ff};
            end
            OFF_LIN_STAT: begin
               rdata_ff <= {4'h0, col_ff, sync_ff, brk_done_ff, brk_seen_ff};
            end
            OFF_TMR_CTRL: begin
               rdata_ff <= {6'h00, tif.run, run_ff};
            end
            OFF_TMR_PRE: begin
               rdata_ff <= tif.count[7:0];
            end
            OFF_TMR_CNT: begin
               rdata_ff <= tif.count[15:8];
            end
            OFF_SER_CTRL1: begin
               rdata_ff <= {7'h00, tx_en_ff};
            end
            default: begin
               rdata_ff <= 8'h00;
            end
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end

   assign RDATA = rdata_ff;
   assign LIN_TX_PIN = tx_ff;
   assign SER_RXD = ser_rxd_ff;
   assign SER_TX_REQ = req_ff;
   assign SER_TX_DATA = data_ff;
   assign SER_TX_EN = tx_en_ff;
   assign TIMER_IRQ = irq_ff;
endmodule : lin_header_assist

// ---- lin_header_assist_props.sv ----
// Concurrent checks on the ports of the LIN header-assist block.
`timescale 1ns/1ps
module lin_header_assist_props (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [lin_pkg::ADDR_W-1:0] ADDR,
   input wire logic [lin_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [lin_pkg::DATA_W-1:0] RDATA,
   input wire logic LIN_RX_PIN,
   input wire logic LIN_TX_PIN,
   input wire logic SER_TXD,
   input wire logic SER_RXD,
   input wire logic SER_TX_REQ,
   input wire logic [lin_pkg::DATA_W-1:0] SER_TX_DATA,
   input wire logic SER_LATCH,
   input wire logic SER_TX_EN,
   input wire logic TIMER_IRQ
);
   import lin_pkg::*;
   logic [7:0] ctl_ff, pre_ff, cnt_ff;
   logic [16:0] low_cnt_ff, brk_len;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // Shadow copies of the control and timer reload writes.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctl_ff <= 8'h00;
         pre_ff <= TMR_PRE_RST;
         cnt_ff <= TMR_CNT_RST;
      end else if (WR) begin
         if (ADDR == OFF_LIN_CTRL) ctl_ff <= WDATA;
         if (ADDR == OFF_TMR_PRE) pre_ff <= WDATA;
         if (ADDR == OFF_TMR_CNT) cnt_ff <= WDATA;
      end
   end
   // Counts how many cycles the transmit pin has stayed low.
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) low_cnt_ff <= 17'h0;
      else low_cnt_ff <= LIN_TX_PIN ? 17'h0 : low_cnt_ff + 17'h1;
   end
   assign brk_len = (17'(pre_ff) + 17'h1) * (17'(cnt_ff) + 17'h1);
   property p_brk_start;
      WR && ADDR == OFF_TMR_CTRL && WDATA[TCT_RUN] && ctl_ff[CTL_LINE] && ctl_ff[CTL_MASTER]
         |-> ##2 !LIN_TX_PIN;
   endproperty
   a_brk_start: assert property (p_brk_start) else $error("break did not start");
   property p_brk_len;
      SER_TX_REQ |-> low_cnt_ff + 17'h1 >= brk_len && low_cnt_ff <= brk_len + 17'h2;
   endproperty
   a_brk_len: assert property (p_brk_len) else $error("break length wrong");
   property p_req_low;
      SER_TX_REQ |-> !$past(LIN_TX_PIN) ##1 !SER_TX_REQ;
   endproperty
   a_req_low: assert property (p_req_low) else $error("sync request not after break");
   property p_req_data;
      SER_TX_REQ |-> SER_TX_DATA == SYNC_BYTE;
   endproperty
   a_req_data: assert property (p_req_data) else $error("sync byte value wrong");
   property p_tx_follow;
      LIN_TX_PIN |-> $past(SER_TXD);
   endproperty
   a_tx_follow: assert property (p_tx_follow) else $error("transmit pin high wrongly");
   property p_irq_off;
      ctl_ff[2:0] == 3'h0 && $past(ctl_ff[2:0]) == 3'h0 |-> !TIMER_IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt while all masked");
   property p_col;
      SER_LATCH && SER_TX_EN && ctl_ff[CTL_LINE] && ctl_ff[CTL_COL_IE] && $stable(LIN_RX_PIN)
         && $past(LIN_RX_PIN, 2) == LIN_RX_PIN && LIN_RX_PIN != LIN_TX_PIN |-> ##[1:3] TIMER_IRQ;
   endproperty
   a_col: assert property (p_col) else $error("collision not flagged");
   property p_mask;
      WR && ADDR == OFF_LIN_CTRL && WDATA[CTL_ARM] && ctl_ff[CTL_LINE] && !ctl_ff[CTL_MASTER]
         |-> ##2 SER_RXD [*3];
   endproperty
   a_mask: assert property (p_mask) else $error("receive not masked after arm");
   property p_txen;
      WR && ADDR == OFF_SER_CTRL1 |=> SER_TX_EN == $past(WDATA[SER_TX_EN_BIT]);
   endproperty
   a_txen: assert property (p_txen) else $error("transmit enable not updated");
   property p_arm_rd;
      RD && ADDR == OFF_LIN_CTRL |=> RDATA[CTL_ARM] == 1'b0;
   endproperty
   a_arm_rd: assert property (p_arm_rd) else $error("arm bit read as one");
   c_req: cover property (SER_TX_REQ);
   c_arm: cover property (WR && ADDR == OFF_LIN_CTRL && WDATA[CTL_ARM]);
   c_slave_irq: cover property (TIMER_IRQ && ctl_ff[CTL_LINE] && !ctl_ff[CTL_MASTER]);
endmodule : lin_header_assist_props
bind lin_header_assist lin_header_assist_props u_lin_header_assist_props (.CLK(CLK),
   .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .LIN_RX_PIN(LIN_RX_PIN), .LIN_TX_PIN(LIN_TX_PIN), .SER_TXD(SER_TXD), .SER_RXD(SER_RXD),
   .SER_TX_REQ(SER_TX_REQ), .SER_TX_DATA(SER_TX_DATA), .SER_LATCH(SER_LATCH),
   .SER_TX_EN(SER_TX_EN), .TIMER_IRQ(TIMER_IRQ));

// ---- lin_bus_node.sv ----
// Model of another LIN node sharing the single-wire bus.
`timescale 1ns/1ps
module lin_bus_node (
   input wire logic clk,
   input wire logic tx_pin,
   output logic rx_pin
);
   logic drv_low = 1'b0;
   // The bus has a pull-up, so either node pulling low wins.
   assign rx_pin = tx_pin & ~drv_low;
   // Holds the bus low for n cycles, then releases it.
   task automatic hold_low(input int n);
      @(posedge clk);
      drv_low <= 1'b1;
      repeat (n) @(posedge clk);
      drv_low <= 1'b0;
   endtask : hold_low
   // Sends start bit, data bits from bit 0 upward, then stop bit.
   task automatic send_byte(input logic [7:0] b, input int blen);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         drv_low <= ~frame[i];
         repeat (blen - 1) @(posedge clk);
      end
   endtask : send_byte
endmodule : lin_bus_node

// ---- testbench.sv ----
// Self-checking bench for the LIN header-assist block.
`timescale 1ns/1ps
module testbench;
   import lin_pkg::*;
   typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} row_type;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ser_txd = 1'b1;
   logic ser_tx_done = 1'b0;
   logic ser_latch = 1'b0;
   logic [7:0] rdata, tx_data, rv, lo;
   logic tx_pin, rx_pin, ser_rxd, tx_req, tx_en, irq;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;
   int lows = 0;
   row_type rows [6] = '{'{OFF_LIN_CTRL, 8'h37, 8'h27}, '{OFF_LIN_CTRL, 8'h10, 8'h00},
      '{OFF_SER_CTRL1, 8'h01, 8'h01}, '{OFF_SER_CTRL1, 8'h00, 8'h00},
      '{3'h6, 8'hFF, 8'h00}, '{3'h7, 8'hFF, 8'h00}};
   lin_header_assist u_lin_header_assist (.CLK(clk), .RST_B(rst_b), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LIN_RX_PIN(rx_pin),
      .LIN_TX_PIN(tx_pin), .SER_TXD(ser_txd), .SER_RXD(ser_rxd), .SER_TX_REQ(tx_req),
      .SER_TX_DATA(tx_data), .SER_TX_DONE(ser_tx_done), .SER_LATCH(ser_latch),
      .SER_TX_EN(tx_en), .TIMER_IRQ(irq));
   lin_bus_node u_lin_bus_node (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
   // Clock of 50 ns period.
   initial begin
      forever #25 clk = ~clk;
   end
   // no block timeout; this ceiling only cuts a hung run short.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   // Other node pulls the bus low while the serial port samples a bit.
   task automatic clash;
      fork
         u_lin_bus_node.hold_low(12);
         begin
            repeat (6) @(posedge clk);
            ser_latch <= 1'b1;
            @(posedge clk);
            ser_latch <= 1'b0;
         end
      join
   endtask : clash
   task automatic end_sim;
      $display("counts: %0d compares, %0d mismatches", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim
   // Main sequence: reset, register rows, master, collision, slave.
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rd_reg(OFF_LIN_STAT, rv);
      chk({tx_pin, irq, rv}, {1'b1, 1'b0, 8'h00});
      $display("done: reset");
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, rv);
         chk(rv, rows[i].e);
      end
      $display("done: register rows");
      wr_reg(OFF_LIN_CTRL, 8'hC2);
      wr_reg(OFF_TMR_PRE, 8'h01);
      wr_reg(OFF_TMR_CNT, 8'h02);
      wr_reg(OFF_TMR_CTRL, 8'h01);
      for (int i = 0; i < 100 && tx_req !== 1'b1; i++) begin
         @(posedge clk);
         #1;
         if (tx_pin === 1'b0) lows++;
      end
      chk(lows >= 5 && lows <= 8, 1'b1);
      chk({tx_req, tx_pin}, 2'h2);
      chk(tx_data, SYNC_BYTE);
      repeat (2) @(posedge clk);
      #1;
      chk(irq, 1'b1);
      chk(tx_pin, 1'b1);
      @(posedge clk);
      ser_tx_done <= 1'b1;
      @(posedge clk);
      ser_tx_done <= 1'b0;
      ser_txd <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(tx_pin, 1'b0);
      @(posedge clk);
      ser_txd <= 1'b1;
      repeat (10) @(posedge clk);
      rd_reg(OFF_LIN_STAT, rv);
      chk(rv, 8'h02);
      wr_reg(OFF_LIN_STAT, 8'h02);
      rd_reg(OFF_LIN_STAT, rv);
      chk({irq, rv}, 9'h000);
      $display("done: master break");
      wr_reg(OFF_LIN_CTRL, 8'hC4);
      clash();
      rd_reg(OFF_LIN_STAT, rv);
      chk(rv, 8'h00);
      wr_reg(OFF_SER_CTRL1, 8'h01);
      clash();
      rd_reg(OFF_LIN_STAT, rv);
      chk({tx_en, irq, rv}, 10'h308);
      wr_reg(OFF_LIN_STAT, 8'h08);
      wr_reg(OFF_SER_CTRL1, 8'h00);
      $display("done: collision");
      // stop after header; line is stopped before the mode changes to slave.
      wr_reg(OFF_LIN_CTRL, 8'h00);
      wr_reg(OFF_LIN_CTRL, 8'hA3);
      wr_reg(OFF_TMR_CNT, 8'h03);
      wr_reg(OFF_LIN_CTRL, 8'hB3);
      rd_reg(OFF_LIN_CTRL, rv);
      chk(rv, 8'hAB);
      u_lin_bus_node.hold_low(4);
      repeat (6) @(posedge clk);
      rd_reg(OFF_LIN_STAT, rv);
      chk(rv, 8'h00);
      u_lin_bus_node.hold_low(20);
      repeat (4) @(posedge clk);
      rd_reg(OFF_LIN_STAT, rv);
      chk({irq, ser_rxd, rv}, 10'h301);
      u_lin_bus_node.send_byte(SYNC_BYTE, 10);
      rd_reg(OFF_LIN_STAT, rv);
      chk(rv, 8'h05);
      rd_reg(OFF_LIN_CTRL, rv);
      chk(rv, 8'hA3);
      rd_reg(OFF_TMR_PRE, lo);
      rd_reg(OFF_TMR_CNT, rv);
      chk({rv, lo} >= 16'd78 && {rv, lo} <= 16'd82, 1'b1);
      wr_reg(OFF_LIN_STAT, 8'h05);
      // Timer reloaded and restarted to watch for a long low.
      wr_reg(OFF_TMR_CTRL, 8'h01);
      u_lin_bus_node.hold_low(20);
      repeat (4) @(posedge clk);
      rd_reg(OFF_LIN_STAT, rv);
      chk(rv, 8'h01);
      wr_reg(OFF_LIN_CTRL, 8'h93);
      u_lin_bus_node.hold_low(20);
      rd_reg(OFF_LIN_CTRL, rv);
      chk({ser_rxd, rv}, 9'h083);
      $display("done: slave header");
      end_sim();
   end
endmodule : testbench
